// ===== design/capture_ctrl_map.vh
// Register map, field positions and reset values of the capture control
`ifndef CAPTURE_CTRL_MAP_VH
`define CAPTURE_CTRL_MAP_VH
`define CTRL_SECOND_ADDR 12'h000
`define TIMER_LOW_ADDR 12'h004
`define TIMER_HIGH_ADDR 12'h008
`define ADDR_WIDTH 12
`define CTRL_WIDTH 16
`define CTRL_RESET 16'h000D
`define CTRL_WRITE_MASK 16'h01DF
`define BIT_CASCADE 8
`define BIT_TRIG_MODE 7
`define BIT_TRIG_STAT 6
`define SRC_MSB 4
`define SRC_LSB 0
`define SRC_WIDTH 5
`define SRC_COUNT 32
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`endif

// ===== design/capture_timer_ctrl.v
// Capture timer second control register with sync and trigger logic
//
// Functional notes
// RULE1: A set cascade bit joins this timer and its partner into 32 bits.
// RULE2: With trigger mode select at 1 the selected source starts the timer.
// RULE3: With trigger mode select at 0 the source resets the timer to sync.
// RULE4: Run status reads 1 while the triggered timer counts, 0 held clear.
// RULE5: Run status is hardware settable, software read/write, reset 0.
// RULE6: Bits 15 to 9 and bit 5 of the control register read as zero.
// RULE7: Software sets the cascade bit in both odd and even modules.
// RULE8: The selected source sets run status; software may set or clear it.
// RULE9: Software never selects this module as its own source.
// RULE10: The timer counts from the clock after the event, zero before.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "capture_ctrl_map.vh"
module capture_timer_ctrl #(
  parameter TIMER_WIDTH = 16,
  parameter SRC_COUNT = `SRC_COUNT
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Source events from other modules, levels or pulses
  input wire [SRC_COUNT-1:0] source_events,
  // Cascade partner: low half rollover arriving from the odd module
  input wire partner_carry,
  // Timer state out
  output reg [TIMER_WIDTH-1:0] capture_timer,
  output reg timer_carry,
  output reg cascade_pair_enable,
  output reg trigger_run_status
);
  reg [`CTRL_WIDTH-1:0] ctrl;
  reg wr_pending;
  reg [`ADDR_WIDTH-1:0] wr_addr;
  reg [TIMER_WIDTH-1:0] next_timer;
  reg next_run;
  reg [`CTRL_WIDTH-1:0] wr_value;
  reg [31:0] read_mux;
  reg src_prev;
  reg carry_prev;
  wire [SRC_COUNT-1:0] events_sync;
  wire carry_sync;
  wire [`SRC_WIDTH-1:0] new_sel;
  wire new_level;
  wire trig_mode;
  wire [`SRC_WIDTH-1:0] src_sel;
  wire src_level;
  wire src_rise;
  wire carry_rise;
  wire count_enable;
  wire addr_ok;
  wire ctrl_write;

  // Sources come from other domains, so resync them first
  sync_two_flop #(.WIDTH(SRC_COUNT)) u_sync_src (
    .clock(clock),
    .nrst(nrst),
    .async_in(source_events),
    .sync_out(events_sync)
  );

  sync_two_flop #(.WIDTH(1)) u_sync_carry (
    .clock(clock),
    .nrst(nrst),
    .async_in(partner_carry),
    .sync_out(carry_sync)
  );

  // Field decode
  assign trig_mode = ctrl[`BIT_TRIG_MODE];
  assign src_sel = ctrl[`SRC_MSB:`SRC_LSB];
  assign src_level = events_sync[src_sel];
  // Level of the source that a pending write is about to select
  assign new_sel = wr_value[`SRC_MSB:`SRC_LSB];
  assign new_level = events_sync[new_sel];
  // Edge detect on synchronised copy only
  assign src_rise = src_level & ~src_prev;
  assign carry_rise = carry_sync & ~carry_prev;
  assign ctrl_write = wr_pending && (wr_addr == `CTRL_SECOND_ADDR);

  // Cascaded upper half steps only on partner rollover
  assign count_enable = cascade_pair_enable ? carry_rise : 1'b1; // RULE1

  // Address phase qualifier
  assign addr_ok = hsel && hready && (htrans == `HTRANS_NONSEQ);

  // Edge history of the selected source; a change of selection reloads it
  // with the new line's level, so a line already high is not an event
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      src_prev <= 1'b0;
    end
    else if (ctrl_write)
    begin
      src_prev <= new_level;
    end
    else
    begin
      src_prev <= src_level;
    end
  end

  // Edge history of the partner rollover
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      carry_prev <= 1'b0;
    end
    else
    begin
      carry_prev <= carry_sync;
    end
  end

  // Control write value; bit 6 follows hardware set over software clear
  always @*
  begin
    wr_value = (hwdata[`CTRL_WIDTH-1:0] & `CTRL_WRITE_MASK); // RULE6
    next_run = trigger_run_status;
    if (ctrl_write)
    begin
      next_run = hwdata[`BIT_TRIG_STAT]; // RULE5 RULE8
    end
    // A source event in the clearing cycle still wins
    if (trig_mode && src_rise)
    begin
      next_run = 1'b1; // RULE8
    end
    if (!trig_mode)
    begin
      next_run = 1'b0; // Sync mode never holds the timer
    end
  end

  // Timer next value per mode
  always @*
  begin
    next_timer = capture_timer;
    if (trig_mode)
    begin
      // Held clear until triggered, count from next clock
      if (trigger_run_status && count_enable)
      begin
        next_timer = capture_timer + 1'b1; // RULE2 RULE10
      end
      else if (!trigger_run_status)
      begin
        next_timer = {TIMER_WIDTH{1'b0}}; // RULE4 RULE10
      end
    end
    else
    begin
      // Sync event realigns to zero, otherwise free-running
      if (src_rise)
      begin
        next_timer = {TIMER_WIDTH{1'b0}}; // RULE3
      end
      else if (count_enable)
      begin
        next_timer = capture_timer + 1'b1; // RULE3
      end
    end
  end

  // Control fields; bit 6 lives in its own flop below
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      ctrl <= `CTRL_RESET;
    end
    else if (ctrl_write)
    begin
      ctrl <= wr_value;
    end
  end

  // Cascade enable copy; the partner module must be set up the same way,
  // this side cannot check that
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      cascade_pair_enable <= 1'b0;
    end
    else if (ctrl_write)
    begin
      cascade_pair_enable <= wr_value[`BIT_CASCADE]; // RULE1 RULE7
    end
  end

  // Run status: hardware set, software write, cleared by reset
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      trigger_run_status <= 1'b0; // RULE5
    end
    else
    begin
      trigger_run_status <= next_run; // RULE4
    end
  end

  // Timer value
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      capture_timer <= {TIMER_WIDTH{1'b0}};
    end
    else
    begin
      capture_timer <= next_timer;
    end
  end

  // Rollover pulse for a cascade partner; one cycle wide, so a partner
  // on another clock must stretch it before sampling
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      timer_carry <= 1'b0;
    end
    else
    begin
      timer_carry <= (next_timer == {TIMER_WIDTH{1'b0}}) &&
        (capture_timer == {TIMER_WIDTH{1'b1}});
    end
  end

  // Read data with live status in bit 6
  always @*
  begin
    read_mux = 32'h00000000;
    case (haddr[`ADDR_WIDTH-1:0])
      `CTRL_SECOND_ADDR:
      begin
        read_mux[`CTRL_WIDTH-1:0] = ctrl & `CTRL_WRITE_MASK; // RULE6
        read_mux[`BIT_TRIG_STAT] = trigger_run_status; // RULE4
      end
      `TIMER_LOW_ADDR:
        read_mux[TIMER_WIDTH-1:0] = capture_timer;
      default:
        read_mux = 32'h00000000;
    endcase
  end

  // Write request is remembered for its data phase, where hwdata stands
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      wr_pending <= 1'b0;
      wr_addr <= {`ADDR_WIDTH{1'b0}};
    end
    else
    begin
      wr_pending <= addr_ok && hwrite;
      wr_addr <= haddr[`ADDR_WIDTH-1:0];
    end
  end

  // Read data captured at the address phase and held until the next read;
  // a read placed right behind a write to the same register sees old data
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addr_ok && !hwrite)
    begin
      hrdata <= read_mux;
    end
  end

  // Zero wait states and always OKAY
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule // capture_timer_ctrl

// ===== design/sync_two_flop.v
// Two flip-flop synchroniser for a vector of level inputs
`timescale 1ns/10ps
module sync_two_flop #(
  parameter WIDTH = 32
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;

  // First stage feeds only the second
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      stage_one <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // sync_two_flop

// ===== tb/ctrl_assertions.sv
// Port-level assertions for the capture control block
`timescale 1ns/10ps
module ctrl_chk #(
  parameter TIMER_WIDTH = 16
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  // Bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // Timer state
  input wire [TIMER_WIDTH-1:0] capture_timer,
  input wire cascade_pair_enable,
  input wire trigger_run_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire take = hsel && htrans == 2'h2 && haddr[11:0] == 12'h000;
  reg wr_ph;
  reg trig_mode;
  // Mode bit has no port, so mirror it from bus writes
  always @(posedge clock)
  begin
    wr_ph <= nrst && take && hwrite;
    trig_mode <= nrst && (wr_ph ? hwdata[7] : trig_mode);
  end
  sequence s_rd; take && !hwrite; endsequence
  sequence s_wr; take && hwrite ##1 1'b1; endsequence
  property p_zero; s_rd |=> hrdata[15:9] == 7'h00 && !hrdata[5]; endproperty
  a_zero: assert property (p_zero) else $error("Unused bits set");
  property p_rd_st; s_rd |=> hrdata[6] == $past(trigger_run_status);
  endproperty
  a_rd_st: assert property (p_rd_st) else $error("Bad status read");
  property p_rd_cs; s_rd |=> hrdata[8] == $past(cascade_pair_enable);
  endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("Bad cascade read");
  property p_wr_cs; s_wr |=> cascade_pair_enable == $past(hwdata[8]);
  endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("Cascade not set");
  property p_reset; $rose(nrst) |-> !trigger_run_status &&
    !cascade_pair_enable && capture_timer == 0; endproperty
  a_reset: assert property (p_reset) else $error("Bad reset state");
  property p_held; (trig_mode && !trigger_run_status) [*2] |->
    capture_timer == 0; endproperty
  a_held: assert property (p_held) else $error("Timer not held");
  // Only runs started without cascade from a held timer give a known count
  property p_start; $rose(trigger_run_status) && trig_mode &&
    !cascade_pair_enable |=> capture_timer == 1; endproperty
  a_start: assert property (p_start) else $error("Late start");
  property p_sync; !trig_mode [*2] |-> !trigger_run_status; endproperty
  a_sync: assert property (p_sync) else $error("Status in sync");
endmodule // ctrl_chk

// ===== tb/source_model.sv
// Far-side trigger sources and cascade partner
`timescale 1ns/10ps
module source_model (
  // Clock
  input wire clock,
  // Bench commands
  input wire [4:0] pick,
  input wire go,
  input wire carry_go,
  // Lines into the block
  output reg [31:0] source_events = 32'h0,
  output reg partner_carry = 1'b0
);
  // Only the picked line moves; never this module's own slot
  always @(posedge clock)
  begin
    source_events <= go ? 32'h1 << pick : 32'h0;
    partner_carry <= carry_go;
  end
endmodule // source_model

// ===== tb/test_capture_timer_sync_trigger_control.sv
// Self-checking bench for the capture control register
`timescale 1ns/10ps
module test_capture_timer_sync_trigger_control;
  // Narrow timer so that a rollover is reached in a short run
  localparam TIMER_WIDTH = 6;
  logic clock = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic go = 1'b0, carry_go = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [1:0] htrans = 2'h0;
  logic [4:0] pick = 5'h3;
  wire [31:0] hrdata, source_events;
  wire hreadyout, hresp, partner_carry, timer_carry;
  wire cascade_pair_enable, trigger_run_status;
  wire [TIMER_WIDTH-1:0] capture_timer;
  int mismatches = 0, checked = 0;
  always #10 clock = ~clock;
  capture_timer_ctrl #(.TIMER_WIDTH(TIMER_WIDTH)) capture_timer_ctrl_inst (
    .clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .source_events,
    .partner_carry, .capture_timer, .timer_carry, .cascade_pair_enable,
    .trigger_run_status);
  source_model source_model_inst (.clock, .pick, .go, .carry_go,
    .source_events, .partner_carry);
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One single word transfer; read data lands in q
  task automatic bus(input logic wr, input logic [11:0] a, input int d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_regs;
    bus(0, 12'h000, 0);
    chk("reset", 32'h0D, q);
    chk("okay", 32'h0, hresp);
    bus(0, 12'h008, 0);
    chk("reserved", 32'h0, q);
    bus(1, 12'h000, 32'hFFFF);
    bus(0, 12'h000, 0);
    // Bit 6 stays clear: sync mode was in force as the write landed
    chk("ones", 32'h19F, q);
    chk("cascade", 32'h1, cascade_pair_enable);
    bus(1, 12'h000, 0);
    bus(0, 12'h000, 0);
    chk("zeros", 32'h0, q);
    $display("register test done");
  endtask
  task automatic t_trig;
    bus(1, 12'h000, 32'h83);
    bus(0, 12'h004, 0);
    chk("held", 32'h0, q);
    @(posedge clock);
    go <= 1'b1;
    // Bounded wait, aligned just after the setting edge
    repeat (20) if (trigger_run_status !== 1'b1) step(1);
    chk("status", 32'h1, trigger_run_status);
    step(5);
    chk("count", 32'h5, capture_timer);
    @(posedge clock);
    go <= 1'b0;
    bus(1, 12'h000, 32'h83);
    bus(0, 12'h004, 0);
    chk("cleared", 32'h0, q);
    $display("trigger test done");
  endtask
  task automatic t_sync;
    bus(1, 12'h000, 32'h03);
    bus(0, 12'h000, 0);
    chk("sync", 32'h03, q);
    @(posedge clock);
    go <= 1'b1;
    repeat (20) if (capture_timer !== 0) step(1);
    chk("synced", 32'h0, capture_timer);
    step(3);
    chk("free run", 32'h3, capture_timer);
    repeat (70) if (capture_timer !== {TIMER_WIDTH{1'b1}}) step(1);
    step(1);
    chk("wrap", 32'h1, timer_carry);
    chk("wrapped", 32'h0, capture_timer);
    step(1);
    chk("carry pulse", 32'h0, timer_carry);
    @(posedge clock);
    go <= 1'b0;
    $display("sync test done");
  endtask
  task automatic t_casc;
    bus(1, 12'h000, 32'h180);
    bus(1, 12'h000, 32'h1C0);
    repeat (3)
    begin
      @(posedge clock);
      carry_go <= 1'b1;
      repeat (3) @(posedge clock);
      carry_go <= 1'b0;
      repeat (3) @(posedge clock);
    end
    step(4);
    bus(0, 12'h004, 0);
    chk("steps", 32'h3, q);
    $display("cascade test done");
  endtask
  // Software set of run status, then a reset in mid-run
  task automatic t_rst;
    bus(1, 12'h000, 32'h83);
    bus(1, 12'h000, 32'h1C3);
    step(1);
    chk("soft set", 32'h1, trigger_run_status);
    @(posedge clock);
    nrst <= 1'b0;
    step(2);
    @(posedge clock);
    nrst <= 1'b1;
    chk("rst status", 32'h0, trigger_run_status);
    chk("rst cascade", 32'h0, cascade_pair_enable);
    bus(0, 12'h000, 0);
    chk("rst ctrl", 32'h0D, q);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_regs;
    t_trig;
    t_sync;
    t_casc;
    t_rst;
    close_out;
  end
  // Hang guard, far beyond the under two hundred cycles needed
  initial
  begin
    #100000;
    mismatches++;
    close_out;
  end
endmodule // test_capture_timer_sync_trigger_control
bind capture_timer_ctrl ctrl_chk #(.TIMER_WIDTH(TIMER_WIDTH)) chk_inst (
  .clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
  .capture_timer, .cascade_pair_enable, .trigger_run_status);
